// file: src/ssh_defines.vh
// constants for the status reporting hierarchy
`ifndef SSH_DEFINES_VH
`define SSH_DEFINES_VH

// ----------------------------------------
// command select field: [5:4] register group, [2:0] part or common item
// ----------------------------------------
`define SSH_SEL_W          6
`define SSH_GRP_COMMON     2'h0
`define SSH_GRP_QUES       2'h1
`define SSH_GRP_HWFAULT    2'h2
`define SSH_GRP_BOUND      2'h3

// common items (group 0)
`define SSH_ITEM_STB       3'h0
`define SSH_ITEM_SRE       3'h1
`define SSH_ITEM_PPE       3'h2
`define SSH_ITEM_ESR       3'h3
`define SSH_ITEM_ESE       3'h4
`define SSH_ITEM_IST       3'h5

// parts of a 16-bit status register (groups 1..3)
`define SSH_PART_LIVE      3'h0
`define SSH_PART_RISE      3'h1
`define SSH_PART_FALL      3'h2
`define SSH_PART_EVENT     3'h3
`define SSH_PART_MASK      3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define SSH_STB_QUES_BIT   3
`define SSH_STB_MAV_BIT    4
`define SSH_STB_ESB_BIT    5
`define SSH_STB_RQS_BIT    6
`define SSH_QUES_HW_BIT    9
`define SSH_QUES_BOUND_BIT 10
`define SSH_STD_OPC_BIT    0
`define SSH_STD_QYE_BIT    2
`define SSH_STD_DDE_BIT    3
`define SSH_STD_EXE_BIT    4
`define SSH_STD_CME_BIT    5
`define SSH_STD_URQ_BIT    6
`define SSH_STD_PON_BIT    7
// bit 1 of the standard event latch has no source
`define SSH_STD_USED_MASK  8'hFD

// ----------------------------------------
// reset values
// ----------------------------------------
`define SSH_RISE_RST       15'h7FFF
`define SSH_FALL_RST       15'h0000
`define SSH_MASK_RST       15'h0000
`define SSH_BYTE_RST       8'h00

`endif

// file: src/ssh_scpi_reg.v
// one five-part 16-bit status register with sum bit
`timescale 1ns/1ps
`default_nettype none
`include "ssh_defines.vh"

module ssh_scpi_reg (
	input  wire        clk_in,
	input  wire        rst_b_in,
	input  wire [14:0] live_in,
	input  wire        wr_in,
	input  wire        rd_in,
	input  wire [2:0]  part_in,
	input  wire [14:0] wdata_in,
	output reg  [15:0] rdata_out,
	output wire        sum_out
);
	reg [14:0] live_q;
	reg [14:0] rise_q;
	reg [14:0] fall_q;
	reg [14:0] event_q;
	reg [14:0] mask_q;
	wire [14:0] rose;
	wire [14:0] fell;
	wire        evt_clr;

	// ----------------------------------------
	// transition filters and event latch
	// ----------------------------------------
	assign rose    = live_in & ~live_q & rise_q; // RULE5
	assign fell    = ~live_in & live_q & fall_q; // RULE6
	assign evt_clr = rd_in && (part_in == `SSH_PART_EVENT); // RULE8
	assign sum_out = |(event_q & mask_q); // RULE9

	always @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			live_q  <= 15'h0000;
			rise_q  <= `SSH_RISE_RST;
			fall_q  <= `SSH_FALL_RST;
			event_q <= 15'h0000;
			mask_q  <= `SSH_MASK_RST;
		end
		else
		begin
			// live part follows inputs only; writes never reach it
			live_q <= live_in; // RULE3 RULE4
			// new edge wins over the read clear in the same cycle
			event_q <= (evt_clr ? 15'h0000 : event_q) | rose | fell; // RULE8
			if (wr_in && part_in == `SSH_PART_RISE)
				rise_q <= wdata_in; // RULE7
			if (wr_in && part_in == `SSH_PART_FALL)
				fall_q <= wdata_in; // RULE7
			if (wr_in && part_in == `SSH_PART_MASK)
				mask_q <= wdata_in; // RULE10
		end
	end

	// ----------------------------------------
	// read mux, bit 15 always zero
	// ----------------------------------------
	always @*
	begin
		case (part_in)
			`SSH_PART_LIVE:  rdata_out = {1'b0, live_q}; // RULE1 RULE2
			`SSH_PART_RISE:  rdata_out = {1'b0, rise_q}; // RULE2
			`SSH_PART_FALL:  rdata_out = {1'b0, fall_q}; // RULE2
			`SSH_PART_EVENT: rdata_out = {1'b0, event_q}; // RULE2
			`SSH_PART_MASK:  rdata_out = {1'b0, mask_q}; // RULE2
			default:         rdata_out = 16'h0000;
		endcase
	end
endmodule // ssh_scpi_reg
`default_nettype wire

// file: src/ssh_std_event.v
// standard event latch with its mask and summary
`timescale 1ns/1ps
`default_nettype none
`include "ssh_defines.vh"

module ssh_std_event (
	input  wire       clk_in,
	input  wire       rst_b_in,
	input  wire [7:0] event_in,
	input  wire       rd_latch_in,
	input  wire       wr_mask_in,
	input  wire [7:0] wdata_in,
	output reg  [7:0] latch_out,
	output reg  [7:0] mask_out,
	output wire       summary_out
);
	always @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			latch_out <= `SSH_BYTE_RST; // RULE25
			mask_out  <= `SSH_BYTE_RST;
		end
		else
		begin
			// set wins over the read clear; unused bit 1 stays zero
			latch_out <= ((rd_latch_in ? 8'h00 : latch_out) | event_in)
				& `SSH_STD_USED_MASK; // RULE23 RULE26
			if (wr_mask_in)
				mask_out <= wdata_in;
		end
	end

	// level summary also covers every enabled 0 to 1 step
	assign summary_out = |(latch_out & mask_out); // RULE17 RULE21
endmodule // ssh_std_event
`default_nettype wire

// file: src/ssh_status_top.v
// status byte, service request and parallel poll around the status registers
// ----------------------------------------
// Notes on behaviour
// RULE1 - five sixteen-bit parts, shared bit positions
// RULE2 - bit fifteen of every part reads zero
// RULE3 - live part follows hardware or lower sum
// RULE4 - live part read-only, reads harmless
// RULE5 - rising edge sets event when rise filter set
// RULE6 - falling edge sets event when fall filter set
// RULE7 - filters freely writable, reads harmless
// RULE8 - event latches until read, read clears it
// RULE9 - sum is OR of event AND mask
// RULE10 - mask part freely writable, reads harmless
// RULE11 - sums feed next higher live bit
// RULE12 - status byte bit six summarises masked bits
// RULE13 - masked status bit rising raises service request
// RULE14 - mask bit six ignored for service request
// RULE15 - status byte via query or serial poll
// RULE16 - status bit three from questionable sum
// RULE17 - status bit five from masked standard events
// RULE18 - message available bit from output buffer
// RULE19 - individual flag is OR of byte AND poll mask
// RULE20 - individual flag answers a parallel poll
// RULE21 - masked standard event rising sets summary bit
// RULE22 - status register queries are answered
// RULE23 - fixed standard event bit positions
// RULE24 - fault sum at bit 9, bound sum 10
// RULE25 - reset clears events, byte, flag, request
// RULE26 - byte-wide status, masks and standard events
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "ssh_defines.vh"

module ssh_status_top (
	input  wire        clk_in,
	input  wire        rst_b_in,
	input  wire [14:0] ques_live_in,
	input  wire [14:0] hw_fault_live_in,
	input  wire [14:0] bound_check_live_in,
	input  wire [7:0]  std_event_in,
	input  wire        message_avail_in,
	input  wire        cmd_valid_in,
	input  wire        cmd_write_in,
	input  wire [5:0]  cmd_sel_in,
	input  wire [15:0] cmd_wdata_in,
	input  wire        spoll_req_in,
	input  wire        ppoll_req_in,
	output reg         rsp_valid_out,
	output reg  [15:0] rsp_data_out,
	output reg         cmd_err_out,
	output reg         spoll_valid_out,
	output reg  [7:0]  spoll_data_out,
	output reg         ppoll_valid_out,
	output reg         ppoll_bit_out,
	output reg         srq_out,
	output reg         ist_out,
	output reg  [7:0]  stb_out
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function masked_any;
		input [7:0] bits;
		input [7:0] mask;
		begin
			masked_any = |(bits & mask);
		end
	endfunction

	reg  [7:0]  sre_q;
	reg  [7:0]  ppe_q;
	reg  [7:0]  stb_d;
	reg         srq_d;
	reg  [15:0] rd_mux;
	reg         sel_ok;
	reg         sel_ro;
	wire [1:0]  grp;
	wire [2:0]  item;
	wire        cmd_rd;
	wire        cmd_wr;
	wire [2:0]  wr_grp;
	wire [2:0]  rd_grp;
	wire [15:0] ques_rdata;
	wire [15:0] hw_rdata;
	wire [15:0] bound_rdata;
	wire        ques_sum;
	wire        hw_sum;
	wire        bound_sum;
	wire [14:0] ques_live;
	wire [7:0]  esr_q;
	wire [7:0]  ese_q;
	wire        event_summary_bit;
	wire [7:0]  srq_mask;

	assign grp    = cmd_sel_in[5:4];
	assign item   = cmd_sel_in[2:0];
	assign cmd_rd = cmd_valid_in && !cmd_write_in;
	assign cmd_wr = cmd_valid_in && cmd_write_in && sel_ok && !sel_ro;
	assign wr_grp = {cmd_wr && grp == `SSH_GRP_BOUND,
		cmd_wr && grp == `SSH_GRP_HWFAULT,
		cmd_wr && grp == `SSH_GRP_QUES};
	assign rd_grp = {cmd_rd && sel_ok && grp == `SSH_GRP_BOUND,
		cmd_rd && sel_ok && grp == `SSH_GRP_HWFAULT,
		cmd_rd && sel_ok && grp == `SSH_GRP_QUES};

	// ----------------------------------------
	// status register hierarchy
	// ----------------------------------------
	// lower sums drive their assigned live bits of the questionable register
	assign ques_live = {ques_live_in[14:11], bound_sum, hw_sum,
		ques_live_in[8:0]}; // RULE11 RULE24

	ssh_scpi_reg u_hw_fault (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.live_in   (hw_fault_live_in),
		.wr_in     (wr_grp[1]),
		.rd_in     (rd_grp[1]),
		.part_in   (item),
		.wdata_in  (cmd_wdata_in[14:0]),
		.rdata_out (hw_rdata),
		.sum_out   (hw_sum)
	);

	ssh_scpi_reg u_bound_check (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.live_in   (bound_check_live_in),
		.wr_in     (wr_grp[2]),
		.rd_in     (rd_grp[2]),
		.part_in   (item),
		.wdata_in  (cmd_wdata_in[14:0]),
		.rdata_out (bound_rdata),
		.sum_out   (bound_sum)
	);

	ssh_scpi_reg u_ques (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.live_in   (ques_live),
		.wr_in     (wr_grp[0]),
		.rd_in     (rd_grp[0]),
		.part_in   (item),
		.wdata_in  (cmd_wdata_in[14:0]),
		.rdata_out (ques_rdata),
		.sum_out   (ques_sum)
	);

	ssh_std_event u_std (
		.clk_in      (clk_in),
		.rst_b_in    (rst_b_in),
		.event_in    (std_event_in),
		.rd_latch_in (cmd_rd && sel_ok && grp == `SSH_GRP_COMMON && item == `SSH_ITEM_ESR),
		.wr_mask_in  (cmd_wr && grp == `SSH_GRP_COMMON && item == `SSH_ITEM_ESE),
		.wdata_in    (cmd_wdata_in[7:0]),
		.latch_out   (esr_q),
		.mask_out    (ese_q),
		.summary_out (event_summary_bit)
	);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always @*
	begin
		sel_ok = 1'b1;
		sel_ro = 1'b0;
		rd_mux = 16'h0000;
		case (grp)
			`SSH_GRP_COMMON:
			begin
				case (item)
					`SSH_ITEM_STB:
					begin
						rd_mux = {8'h00, stb_out}; // RULE15 RULE22
						sel_ro = 1'b1;
					end
					`SSH_ITEM_SRE: rd_mux = {8'h00, sre_q};
					`SSH_ITEM_PPE: rd_mux = {8'h00, ppe_q};
					`SSH_ITEM_ESR:
					begin
						rd_mux = {8'h00, esr_q}; // RULE22
						sel_ro = 1'b1;
					end
					`SSH_ITEM_ESE: rd_mux = {8'h00, ese_q};
					`SSH_ITEM_IST:
					begin
						rd_mux = {15'h0000, ist_out};
						sel_ro = 1'b1;
					end
					default: sel_ok = 1'b0;
				endcase
			end
			default:
			begin
				// live and event parts refuse writes
				sel_ok = (item <= `SSH_PART_MASK) && (cmd_sel_in[3] == 1'b0);
				sel_ro = (item == `SSH_PART_LIVE) || (item == `SSH_PART_EVENT); // RULE4
				case (grp)
					`SSH_GRP_QUES:    rd_mux = ques_rdata; // RULE22
					`SSH_GRP_HWFAULT: rd_mux = hw_rdata;
					default:          rd_mux = bound_rdata;
				endcase
			end
		endcase
		// select bit three is reserved in every group, common items too
		if (cmd_sel_in[3])
			sel_ok = 1'b0;
		if (!sel_ok)
			rd_mux = 16'h0000;
	end

	// ----------------------------------------
	// status byte and request logic
	// ----------------------------------------
	// mask bit six never takes part in the request
	assign srq_mask = sre_q & 8'hBF; // RULE14

	always @*
	begin
		stb_d = 8'h00;
		stb_d[`SSH_STB_QUES_BIT] = ques_sum; // RULE16
		stb_d[`SSH_STB_MAV_BIT]  = message_avail_in; // RULE18
		stb_d[`SSH_STB_ESB_BIT]  = event_summary_bit; // RULE17 RULE21
		stb_d[`SSH_STB_RQS_BIT]  = masked_any(stb_d, srq_mask); // RULE12
		// a fresh masked rise raises the request; serial poll or no masked status bit set drops it
		srq_d = srq_out;
		if (spoll_req_in || !masked_any(stb_d, srq_mask))
			srq_d = 1'b0;
		if (masked_any(stb_d & ~stb_out, srq_mask))
			srq_d = 1'b1; // RULE13
	end

	always @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sre_q           <= `SSH_BYTE_RST;
			ppe_q           <= `SSH_BYTE_RST;
			stb_out         <= `SSH_BYTE_RST; // RULE25
			srq_out         <= 1'b0;
			ist_out         <= 1'b0;
			rsp_valid_out   <= 1'b0;
			rsp_data_out    <= 16'h0000;
			cmd_err_out     <= 1'b0;
			spoll_valid_out <= 1'b0;
			spoll_data_out  <= `SSH_BYTE_RST;
			ppoll_valid_out <= 1'b0;
			ppoll_bit_out   <= 1'b0;
		end
		else
		begin
			stb_out <= stb_d;
			srq_out <= srq_d;
			ist_out <= masked_any(stb_d, ppe_q); // RULE19
			if (cmd_wr && grp == `SSH_GRP_COMMON && item == `SSH_ITEM_SRE)
				sre_q <= cmd_wdata_in[7:0];
			if (cmd_wr && grp == `SSH_GRP_COMMON && item == `SSH_ITEM_PPE)
				ppe_q <= cmd_wdata_in[7:0];
			// reads answer one cycle later; unmapped or refused shows as error
			rsp_valid_out <= cmd_rd;
			rsp_data_out  <= cmd_rd ? rd_mux : 16'h0000; // RULE22
			cmd_err_out   <= cmd_valid_in && (!sel_ok || (cmd_write_in && sel_ro));
			spoll_valid_out <= spoll_req_in;
			spoll_data_out  <= spoll_req_in ? stb_out : 8'h00; // RULE15
			ppoll_valid_out <= ppoll_req_in;
			ppoll_bit_out   <= ppoll_req_in & ist_out; // RULE20
		end
	end
endmodule // ssh_status_top
`default_nettype wire

// file: tb/ssh_status_top_assertions.sv
// port checker for the status hierarchy top
`timescale 1ns/1ps
`default_nettype none
// ---
// checker
// ---
module ssh_status_top_assertions (
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic        message_avail_in,
	input wire logic        cmd_valid_in,
	input wire logic        cmd_write_in,
	input wire logic [5:0]  cmd_sel_in,
	input wire logic        spoll_req_in,
	input wire logic        ppoll_req_in,
	input wire logic        rsp_valid_out,
	input wire logic [15:0] rsp_data_out,
	input wire logic        cmd_err_out,
	input wire logic        spoll_valid_out,
	input wire logic [7:0]  spoll_data_out,
	input wire logic        ppoll_valid_out,
	input wire logic        ppoll_bit_out,
	input wire logic        srq_out,
	input wire logic        ist_out,
	input wire logic [7:0]  stb_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic rd_ask = cmd_valid_in & ~cmd_write_in;
	wire logic ro_wr  = cmd_valid_in & cmd_write_in & ((!cmd_sel_in[3]
		& (cmd_sel_in[2:0] == 3'h0 | cmd_sel_in[2:0] == 3'h3)) | cmd_sel_in == 6'h05);
	sequence s_spoll;
		spoll_req_in ##1 spoll_valid_out;
	endsequence
	sequence s_ppoll;
		ppoll_req_in ##1 ppoll_valid_out;
	endsequence
	a_read_answer: assert property (rsp_valid_out == $past(rd_ask))
		else $error("read answer pulse wrong");
	a_top_bit_zero: assert property (rsp_data_out[15] == 1'b0)
		else $error("bit 15 of read data set");
	a_idle_data: assert property (!rsp_valid_out |-> rsp_data_out == 16'h0000)
		else $error("read data not zero while idle");
	a_ro_write_err: assert property (ro_wr |=> cmd_err_out)
		else $error("write to read-only item not refused");
	a_spoll_byte: assert property (spoll_req_in |-> s_spoll ##0
		spoll_data_out == $past(stb_out))
		else $error("serial poll answer wrong");
	a_ppoll_flag: assert property (ppoll_req_in |-> s_ppoll ##0
		ppoll_bit_out == $past(ist_out))
		else $error("parallel poll answer missing");
	a_mav_bit: assert property ($past(rst_b_in) |-> stb_out[4] == $past(message_avail_in))
		else $error("message available bit wrong");
	a_srq_summary: assert property (srq_out |-> stb_out[6])
		else $error("service request without summary bit");
	a_stb_unused: assert property (stb_out[2:0] == 3'h0 && !stb_out[7])
		else $error("unused status byte bit set");
endmodule // ssh_status_top_assertions
bind ssh_status_top ssh_status_top_assertions ssh_status_top_assertions_i (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .message_avail_in(message_avail_in),
	.cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in), .cmd_sel_in(cmd_sel_in),
	.spoll_req_in(spoll_req_in), .ppoll_req_in(ppoll_req_in), .rsp_valid_out(rsp_valid_out),
	.rsp_data_out(rsp_data_out), .cmd_err_out(cmd_err_out), .spoll_valid_out(spoll_valid_out),
	.spoll_data_out(spoll_data_out), .ppoll_valid_out(ppoll_valid_out),
	.ppoll_bit_out(ppoll_bit_out), .srq_out(srq_out), .ist_out(ist_out),
	.stb_out(stb_out));
`default_nettype wire

// file: tb/ssh_ctrl_model.sv
// remote controller model: register commands and polls
`timescale 1ns/1ps
`default_nettype none
// ---
// controller
// ---
module ssh_ctrl_model (
	input  wire logic       clk_in,
	output var logic        cmd_valid_out,
	output var logic        cmd_write_out,
	output var logic [5:0]  cmd_sel_out,
	output var logic [15:0] cmd_wdata_out,
	output var logic        spoll_req_out,
	output var logic        ppoll_req_out
);
	logic [16:0] exp_q[$];
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_sel_out = 6'h00;
		cmd_wdata_out = 16'h0000;
		spoll_req_out = 1'b0;
		ppoll_req_out = 1'b0;
	end
	// e is {error, data}; writes note only an expected refusal
	task automatic cmd(input logic w, input logic [5:0] s, input logic [15:0] d,
		input logic [16:0] e);
	begin
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = w;
		cmd_sel_out = s;
		cmd_wdata_out = d;
		if (!w || e[16])
			exp_q.push_back(e);
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		// released lines show junk so stale values never pass for valid
		cmd_write_out = ~w;
		cmd_sel_out = ~s;
		cmd_wdata_out = ~d;
	end
	endtask
	task automatic poll(input logic par, input logic [16:0] e);
	begin
		@(negedge clk_in);
		spoll_req_out = !par;
		ppoll_req_out = par;
		exp_q.push_back(e);
		@(negedge clk_in);
		spoll_req_out = 1'b0;
		ppoll_req_out = 1'b0;
	end
	endtask
endmodule // ssh_ctrl_model
`default_nettype wire

// file: tb/ssh_status_top_tb.sv
// self-checking bench for the status hierarchy top
`timescale 1ns/1ps
`default_nettype none
// ---
// bench
// ---
module ssh_status_top_tb;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [14:0] lv [1:3];
	logic [14:0] rf [1:3];
	logic [14:0] ff [1:3];
	logic [14:0] ev [1:3];
	logic [7:0]  std_ev = 8'h00;
	logic        message_available_bit = 1'b0;
	logic [31:0] seed = 32'h72AE3DE4;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;
	wire logic   cv, cw, sr, pr, rv, ce, sv, pv, pb, srq, individual_status_flag;
	wire logic [5:0]  cs;
	wire logic [15:0] cd, rd;
	wire logic [7:0]  sd, stb;
	always #2 clk_in = ~clk_in;
	ssh_ctrl_model ctl (.clk_in(clk_in), .cmd_valid_out(cv), .cmd_write_out(cw),
		.cmd_sel_out(cs), .cmd_wdata_out(cd), .spoll_req_out(sr), .ppoll_req_out(pr));
	ssh_status_top ssh_status_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.ques_live_in(lv[1]), .hw_fault_live_in(lv[2]), .bound_check_live_in(lv[3]),
		.std_event_in(std_ev), .message_avail_in(message_available_bit), .cmd_valid_in(cv),
		.cmd_write_in(cw), .cmd_sel_in(cs), .cmd_wdata_in(cd), .spoll_req_in(sr),
		.ppoll_req_in(pr), .rsp_valid_out(rv), .rsp_data_out(rd), .cmd_err_out(ce),
		.spoll_valid_out(sv), .spoll_data_out(sd), .ppoll_valid_out(pv),
		.ppoll_bit_out(pb), .srq_out(srq), .ist_out(individual_status_flag), .stb_out(stb));
	task automatic finish_test;
	begin
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
	begin
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	end
	endtask
	// edges are tracked here so expectations never come from the design
	task automatic live(input int g, input logic [14:0] v);
	begin
		@(negedge clk_in);
		ev[g] = ev[g] | (~lv[g] & v & rf[g]) | (lv[g] & ~v & ff[g]);
		lv[g] = v;
		@(negedge clk_in);
	end
	endtask
	always @(negedge clk_in)
		if (rv === 1'b1 || ce === 1'b1 || sv === 1'b1 || pv === 1'b1)
		begin
			if (ctl.exp_q.size() == 0)
				chk("extra answer", 17'h00000, 17'h1FFFF);
			else
				chk("answer", ctl.exp_q.pop_front(),
					{ce, rv ? rd : sv ? {8'h00, sd} : {15'h0000, pb}});
		end
	// ceiling well above the few hundred cycles the run needs
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			finish_test;
		end
	end
	initial
	begin
		int g;
		int i;
		logic [31:0] r;
		for (g = 1; g < 4; g++)
		begin
			lv[g] = 15'h0000;
			rf[g] = 15'h7FFF;
			ff[g] = 15'h0000;
			ev[g] = 15'h0000;
		end
		repeat (3) @(negedge clk_in);
		rst_b_in = 1'b1;
		for (i = 1; i < 5; i++)
			ctl.cmd(1'b0, i[5:0], 16'h0000, 17'h00000);
		for (g = 1; g < 4; g++)
		begin
			ctl.cmd(1'b0, {g[1:0], 4'h1}, 16'h0000, 17'h07FFF);
			ctl.cmd(1'b0, {g[1:0], 4'h3}, 16'h0000, 17'h00000);
			r = $random(seed);
			rf[g] = r[14:0];
			ff[g] = r[30:16];
			ctl.cmd(1'b1, {g[1:0], 4'h1}, {1'b0, rf[g]}, 17'h00000);
			ctl.cmd(1'b1, {g[1:0], 4'h2}, {1'b0, ff[g]}, 17'h00000);
			for (i = 0; i < 4; i++)
			begin
				r = $random(seed);
				live(g, r[14:0] & (g == 1 ? 15'h79FF : 15'h7FFF));
			end
			ctl.cmd(1'b0, {g[1:0], 4'h0}, 16'h0000, {2'b00, lv[g]});
			ctl.cmd(1'b1, {g[1:0], 4'h0}, 16'hFFFF, 17'h10000);
			ctl.cmd(1'b0, {g[1:0], 4'h0}, 16'h0000, {2'b00, lv[g]});
			live(g, 15'h0000);
			ctl.cmd(1'b0, {g[1:0], 4'h3}, 16'h0000, {2'b00, ev[g]});
			ev[g] = 15'h0000;
			ctl.cmd(1'b0, {g[1:0], 4'h3}, 16'h0000, 17'h00000);
			ctl.cmd(1'b1, {g[1:0], 4'h3}, 16'hFFFF, 17'h10000);
		end
		for (g = 1; g < 4; g++)
			for (i = 1; i < 4; i++)
			begin
				r = $random(seed);
				ctl.cmd(1'b1, {g[1:0], 1'b0, i == 3 ? 3'h4 : i[2:0]}, r[15:0] | 16'h8000,
					17'h00000);
				repeat (2) ctl.cmd(1'b0, {g[1:0], 1'b0, i == 3 ? 3'h4 : i[2:0]}, 16'h0000,
					{2'b00, r[14:0]});
			end
		rf[2] = 15'h0001;
		ctl.cmd(1'b1, 6'h21, 16'h0001, 17'h00000);
		ctl.cmd(1'b1, 6'h24, 16'h0001, 17'h00000);
		ctl.cmd(1'b1, 6'h11, 16'h0200, 17'h00000);
		ctl.cmd(1'b1, 6'h14, 16'h0200, 17'h00000);
		ctl.cmd(1'b1, 6'h34, 16'h0000, 17'h00000);
		ctl.cmd(1'b1, 6'h01, 16'h0008, 17'h00000);
		ctl.cmd(1'b1, 6'h02, 16'h0040, 17'h00000);
		live(2, 15'h0001);
		repeat (6) @(negedge clk_in);
		chk("srq", 17'h00001, {16'h0000, srq});
		chk("ist", 17'h00001, {16'h0000, individual_status_flag});
		ctl.poll(1'b0, 17'h00048);
		ctl.poll(1'b1, 17'h00001);
		chk("srq", 17'h00000, {16'h0000, srq});
		ctl.cmd(1'b0, 6'h10, 16'h0000, 17'h00200);
		ctl.cmd(1'b0, 6'h13, 16'h0000, 17'h00200);
		ctl.cmd(1'b1, 6'h31, 16'h0001, 17'h00000);
		ctl.cmd(1'b1, 6'h34, 16'h0001, 17'h00000);
		live(3, 15'h0001);
		repeat (4) @(negedge clk_in);
		ctl.cmd(1'b0, 6'h10, 16'h0000, 17'h00600);
		chk("stb", 17'h00000, {9'h000, stb});
		ctl.cmd(1'b1, 6'h01, 16'h0040, 17'h00000);
		message_available_bit = 1'b1;
		repeat (3) @(negedge clk_in);
		chk("srq", 17'h00000, {16'h0000, srq});
		ctl.poll(1'b0, 17'h00010);
		message_available_bit = 1'b0;
		ctl.cmd(1'b1, 6'h01, 16'h0010, 17'h00000);
		message_available_bit = 1'b1;
		repeat (3) @(negedge clk_in);
		chk("srq", 17'h00001, {16'h0000, srq});
		ctl.poll(1'b0, 17'h00050);
		ctl.cmd(1'b1, 6'h04, 16'h0001, 17'h00000);
		for (i = 0; i < 8; i++)
		begin
			@(negedge clk_in);
			std_ev = 8'h01 << i;
			@(negedge clk_in);
			std_ev = 8'h00;
			if (i == 0)
				ctl.poll(1'b0, 17'h00070);
			ctl.cmd(1'b0, 6'h03, 16'h0000, {9'h000, (8'h01 << i) & 8'hFD});
		end
		ctl.cmd(1'b0, 6'h06, 16'h0000, 17'h10000);
		ctl.cmd(1'b0, 6'h15, 16'h0000, 17'h10000);
		ctl.cmd(1'b0, 6'h08, 16'h0000, 17'h10000);
		ctl.cmd(1'b1, 6'h05, 16'h00FF, 17'h10000);
		ctl.cmd(1'b1, 6'h00, 16'h00FF, 17'h10000);
		@(negedge clk_in);
		rst_b_in = 1'b0;
		@(negedge clk_in);
		chk("reset", 17'h00000, {7'h00, stb, srq, individual_status_flag});
		rst_b_in = 1'b1;
		ctl.cmd(1'b0, 6'h01, 16'h0000, 17'h00000);
		repeat (4) @(negedge clk_in);
		chk("left", 17'h00000, ctl.exp_q.size());
		finish_test;
	end
endmodule // ssh_status_top_tb
`default_nettype wire
